/* ext_data_pkg.sv */
// shared constants and types for the external data page block
package ext_data_pkg;
  localparam int unsigned data_bytes = 32;
  localparam logic [7:0] sense_opcode = 8'h1a;
  localparam logic [5:0] page_code_ext = 6'h3e;
  localparam logic [5:0] page_code_all = 6'h3f;
  localparam logic [7:0] page_len_byte = 8'h20;
  localparam logic [7:0] header_len = 8'h04;
  localparam logic [7:0] page_total = 8'h22;
  localparam logic [7:0] list_total = 8'h26;
  localparam logic [7:0] sense_len_byte = 8'h25;
  localparam logic [7:0] data_first = 8'h06;
  localparam logic [7:0] ps_pos = 8'h04;
  localparam logic [7:0] plen_pos = 8'h05;
  localparam logic [3:0] key_illegal = 4'h5;
  localparam logic [7:0] asc_list_len = 8'h1a;
  localparam logic [7:0] asc_bad_param = 8'h26;
  localparam logic [7:0] asc_bad_cdb = 8'h24;
  localparam logic [7:0] ascq_none = 8'h00;
  localparam logic [15:0] fp_cmd_len = 16'h0004;
  localparam logic [15:0] fp_cmd_page = 16'h0002;
  localparam logic [15:0] fp_cmd_ctrl = 16'h0005;
  localparam logic [15:0] fp_cmd_op = 16'h0000;
  localparam logic [2:0] bit_ps = 3'h7;
  localparam logic [1:0] pc_current = 2'h0;
  localparam logic [1:0] pc_changeable = 2'h1;
  localparam logic [1:0] pc_default = 2'h2;
  localparam logic [1:0] pc_saved = 2'h3;

  typedef struct packed {
    logic [7:0] opcode;
    logic block_descriptor_disable;
    logic [1:0] page_control_field;
    logic [5:0] page_code;
    logic [7:0] alloc_len;
    logic flag;
    logic link;
  } sense_cmd_type;

  typedef struct packed {
    logic check;
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic in_command;
    logic bit_valid;
    logic [2:0] bit_ptr;
    logic [15:0] field_ptr;
  } status_type;
endpackage : ext_data_pkg

/* ext_data_store.sv */
// retained 32-byte external data array with one write and one read port
`timescale 1ns/1ps
module ext_data_store (
  input wire logic clk,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata
);
  // no reset: contents model the battery-backed cells and outlive reset
  logic [7:0] mem [ext_data_pkg::data_bytes];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule : ext_data_store

/* ext_data_page.sv */
// mode select / mode sense handling of the external data page
// How it works
// - keep 32 retained external data bytes
// - never alter or interpret stored bytes itself
// - only successful select of page writes
// - sense of page returns stored bytes
// - page byte 0 is code 3E
// - page byte 1 is length 20h
// - page bytes 2 to 33 hold data
// - wrong list length: key 5, 1A, ptr 0004
// - bad list field: key 5, 26, data pointer
// - savable flag set: 26 with bit 7
// - block descriptor disable bit ignored
// - zero allocation length sends nothing
// - page control picks current, mask, default, saved
`timescale 1ns/1ps
module ext_data_page (
  input wire logic clk,
  input wire logic resetn,
  input wire logic store_valid,
  input wire logic sense_req,
  input wire ext_data_pkg::sense_cmd_type sense_cmd,
  input wire logic sel_req,
  input wire logic [7:0] sel_len,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready,
  output logic done,
  output ext_data_pkg::status_type status
);
  typedef enum logic [2:0] {
    st_idle, st_rx, st_commit, st_tx
  } state_type;

  state_type state_q;
  logic [7:0] cnt_q;
  logic [7:0] limit_q;
  logic [1:0] pc_q;
  logic err_q;
  ext_data_pkg::status_type err_stat_q;
  logic [7:0] stage_q [ext_data_pkg::data_bytes];
  logic [7:0] rdata;
  logic [4:0] raddr;
  logic [7:0] tx_byte;
  logic tx_fire;
  logic last_tx;

  function automatic ext_data_pkg::status_type reject(
    input logic [7:0] asc, input logic in_cmd, input logic bv,
    input logic [15:0] fp);
    ext_data_pkg::status_type s;
    s.check = 1'b1;
    s.key = ext_data_pkg::key_illegal;
    s.asc = asc;
    s.ascq = ext_data_pkg::ascq_none;
    s.in_command = in_cmd;
    s.bit_valid = bv;
    // bit pointer only means something when bit_valid is set
    s.bit_ptr = bv ? ext_data_pkg::bit_ps : 3'h0;
    s.field_ptr = fp;
    return s;
  endfunction : reject

  // byte p of the header plus page; page control picks the data view
  function automatic logic [7:0] sense_byte(
    input logic [7:0] p, input logic [1:0] pc, input logic nv,
    input logic [7:0] d);
    logic [7:0] b;
    b = 8'h00;
    if (p == 8'h00) begin
      b = ext_data_pkg::sense_len_byte;
    end else if (p == ext_data_pkg::ps_pos) begin
      b = {2'b00, ext_data_pkg::page_code_ext};
    end else if (p == ext_data_pkg::plen_pos) begin
      b = ext_data_pkg::page_len_byte;
    end else if (p >= ext_data_pkg::data_first) begin
      case (pc)
        ext_data_pkg::pc_changeable: b = 8'hff;
        ext_data_pkg::pc_default: b = 8'h00;
        default: b = nv ? d : 8'h00;
      endcase
    end
    return b;
  endfunction : sense_byte

  assign raddr = 5'(cnt_q - ext_data_pkg::data_first);
  assign tx_byte = sense_byte(cnt_q, pc_q, store_valid, rdata);
  assign tx_fire = out_valid && out_ready;
  assign last_tx = (cnt_q + 8'h01 == limit_q);

  // store is written only from the staging copy after a clean select
  ext_data_store u_store (
    .clk(clk),
    .we(state_q == st_commit),
    .waddr(cnt_q[4:0]),
    .wdata(stage_q[cnt_q[4:0]]),
    .raddr(raddr),
    .rdata(rdata)
  );

  // main sequencing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= st_idle;
      cnt_q <= 8'h00;
      limit_q <= 8'h00;
      pc_q <= ext_data_pkg::pc_current;
      done <= 1'b0;
      status <= '0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
      out_last <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        st_idle: begin
          cnt_q <= 8'h00;
          if (sense_req) begin
            pc_q <= sense_cmd.page_control_field;
            if (sense_cmd.opcode != ext_data_pkg::sense_opcode) begin
              done <= 1'b1;
              status <= reject(ext_data_pkg::asc_bad_cdb, 1'b1, 1'b0,
                ext_data_pkg::fp_cmd_op);
            end else if (sense_cmd.flag || sense_cmd.link) begin
              done <= 1'b1;
              status <= reject(ext_data_pkg::asc_bad_cdb, 1'b1, 1'b0,
                ext_data_pkg::fp_cmd_ctrl);
            end else if (sense_cmd.page_code != ext_data_pkg::page_code_ext
                && sense_cmd.page_code != ext_data_pkg::page_code_all) begin
              done <= 1'b1;
              status <= reject(ext_data_pkg::asc_bad_cdb, 1'b1, 1'b0,
                ext_data_pkg::fp_cmd_page);
            end else if (sense_cmd.alloc_len == 8'h00) begin
              done <= 1'b1;
              status <= '0;
            end else begin
              limit_q <= (sense_cmd.alloc_len < ext_data_pkg::list_total)
                ? sense_cmd.alloc_len : ext_data_pkg::list_total;
              state_q <= st_tx;
            end
          end else if (sel_req) begin
            if (sel_len != ext_data_pkg::list_total) begin
              done <= 1'b1;
              status <= reject(ext_data_pkg::asc_list_len, 1'b1, 1'b0,
                ext_data_pkg::fp_cmd_len);
            end else begin
              in_ready <= 1'b1;
              state_q <= st_rx;
            end
          end
        end
        st_rx: begin
          if (in_valid) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q + 8'h01 == ext_data_pkg::list_total) begin
              in_ready <= 1'b0;
              cnt_q <= 8'h00;
              if (err_q) begin
                done <= 1'b1;
                status <= err_stat_q;
                state_q <= st_idle;
              end else begin
                state_q <= st_commit;
              end
            end
          end
        end
        st_commit: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(ext_data_pkg::data_bytes - 1)) begin
            done <= 1'b1;
            status <= '0;
            state_q <= st_idle;
          end
        end
        st_tx: begin
          // one byte held until taken; sram read is combinational
          if (!out_valid) begin
            out_valid <= 1'b1;
            out_data <= tx_byte;
            out_last <= last_tx;
          end else if (tx_fire) begin
            out_valid <= 1'b0;
            out_last <= 1'b0;
            cnt_q <= cnt_q + 8'h01;
            if (out_last) begin
              done <= 1'b1;
              status <= '0;
              state_q <= st_idle;
            end
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // field checks on the page; the first fault found is the one reported
  always_ff @(posedge clk) begin
    if (!resetn) begin
      err_q <= 1'b0;
      err_stat_q <= '0;
    end else if (state_q == st_idle) begin
      err_q <= 1'b0;
    end else if (state_q == st_rx && in_valid && !err_q) begin
      if (cnt_q == ext_data_pkg::ps_pos && in_data[7]) begin
        err_q <= 1'b1;
        err_stat_q <= reject(ext_data_pkg::asc_bad_param, 1'b0, 1'b1,
          16'(cnt_q));
      end else if (cnt_q == ext_data_pkg::ps_pos
          && in_data[6:0] != {1'b0, ext_data_pkg::page_code_ext}) begin
        err_q <= 1'b1;
        err_stat_q <= reject(ext_data_pkg::asc_bad_param, 1'b0, 1'b0,
          16'(cnt_q));
      end else if (cnt_q == ext_data_pkg::plen_pos
          && in_data != ext_data_pkg::page_len_byte) begin
        err_q <= 1'b1;
        err_stat_q <= reject(ext_data_pkg::asc_bad_param, 1'b0, 1'b0,
          16'(cnt_q));
      end
    end
  end

  // staging copy of incoming data bytes
  always_ff @(posedge clk) begin
    if (state_q == st_rx && in_valid
        && cnt_q >= ext_data_pkg::data_first) begin
      stage_q[raddr] <= in_data;
    end
  end
endmodule : ext_data_page

/* ext_data_page_properties.sv */
// port assertions for the external data page block
`timescale 1ns/1ps
module ext_data_page_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sense_req,
  input wire ext_data_pkg::sense_cmd_type sense_cmd,
  input wire logic sel_req,
  input wire logic [7:0] sel_len,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_ready,
  input wire logic done,
  input wire ext_data_pkg::status_type status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic idle;
  logic good;
  // commit cycles are invisible here, so requests are only sent after done
  assign idle = !in_ready && !out_valid && !done;
  assign good = sense_cmd.opcode == 8'h1a && sense_cmd.page_code == 6'h3e
    && sense_cmd.alloc_len != 8'h00 && !sense_cmd.flag && !sense_cmd.link;
  chk_len_reject: assert property (sel_req && idle && sel_len != 8'h26 |=>
    done && status.asc == 8'h1a && status.field_ptr == 16'h0004)
    else $error("length reject wrong");
  chk_sel_open: assert property (sel_req && idle && sel_len == 8'h26 |=>
    in_ready) else $error("select did not open");
  chk_zero_alloc: assert property (sense_req && idle
    && sense_cmd.alloc_len == 8'h00 |=> done && !out_valid)
    else $error("zero allocation sent data");
  chk_first_byte: assert property (sense_req && idle && good |=>
    ##1 out_valid && out_data == 8'h25) else $error("first byte wrong");
  chk_byte_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("byte not held");
  chk_ps_reject: assert property (done && status.bit_valid |->
    status.bit_ptr == 3'h7 && status.asc == 8'h26) else $error("bit ptr");
  chk_field_key: assert property (done && status.asc == 8'h26 |->
    status.check && status.key == 4'h5) else $error("field error key");
  chk_no_overlap: assert property (!(in_ready && out_valid))
    else $error("select and sense overlap");
  cover property (done && status.check);
  cover property (out_valid && !out_ready);
  cover property (out_valid && out_ready && out_data == 8'h3e);
endmodule : ext_data_page_properties
bind ext_data_page ext_data_page_properties chk (.clk(clk), .resetn(resetn),
  .sense_req(sense_req), .sense_cmd(sense_cmd), .sel_req(sel_req),
  .sel_len(sel_len), .in_ready(in_ready), .out_valid(out_valid),
  .out_data(out_data), .out_ready(out_ready), .done(done), .status(status));

/* host_model.sv */
// initiator side: takes sense bytes, promptly or with stalls
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  logic [7:0] rx [0:63];
  int rx_n = 0;
  int last_n = 0;
  logic tog = 1'b0;
  initial out_ready = 1'b0;
  // a slow host accepts every other cycle so each byte must stand
  always @(posedge clk) begin
    tog <= ~tog;
    out_ready <= ~slow | tog;
    if (clr) begin
      rx_n <= 0;
      last_n <= 0;
    end else if (out_valid && out_ready && rx_n < 64) begin
      rx[rx_n] <= out_data;
      rx_n <= rx_n + 1;
      if (out_last) begin
        last_n <= rx_n + 1;
      end
    end
  end
endmodule : host_model

/* testbench.sv */
// self-checking bench for the external data page block
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sense_req = 1'b0;
  ext_data_pkg::sense_cmd_type sense_cmd = '0;
  logic sel_req = 1'b0;
  logic [7:0] sel_len = 8'h00;
  logic in_valid = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic slow = 1'b0;
  logic clr = 1'b0;
  logic nv = 1'b1;
  logic in_ready, out_valid, out_last, out_ready, done;
  logic [7:0] out_data;
  ext_data_pkg::status_type status;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  // row: page 3f, slow host, descriptor disable, page control, allocation
  logic [12:0] rows [0:5] = '{13'h0026, 13'h0926, 13'h060a, 13'h0307,
    13'h0000, 13'h18ff};
  always #50 clk = ~clk;
  ext_data_page DUT (.clk(clk), .resetn(resetn), .store_valid(nv),
    .sense_req(sense_req), .sense_cmd(sense_cmd), .sel_req(sel_req),
    .sel_len(sel_len), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready), .done(done), .status(status));
  host_model host (.clk(clk), .clr(clr), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  function automatic logic [7:0] exp_byte(input int j, input logic [1:0] pc);
    case (j)
      0: return 8'h25;
      1, 2, 3: return 8'h00;
      4: return 8'h3e;
      5: return 8'h20;
      default: return pc == 2'h1 ? 8'hff
        : pc == 2'h2 || !nv ? 8'h00 : 8'(j) ^ 8'ha5;
    endcase
  endfunction : exp_byte
  task automatic wait_done();
    int i;
    i = 0;
    while (done !== 1'b1 && i < 300) begin
      @(posedge clk);
      i++;
    end
    if (i >= 300) begin
      err_count++;
    end
  endtask : wait_done
  task automatic sense(input logic [12:0] r, input logic [7:0] op);
    int n;
    n = op != 8'h1a ? 0 : r[7:0] < 38 ? r[7:0] : 38;
    @(posedge clk);
    clr <= 1'b1;
    slow <= r[11];
    sense_cmd <= '{op, r[10], r[9:8], r[12] ? 6'h3f : 6'h3e, r[7:0], 1'b0,
      1'b0};
    sense_req <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    sense_req <= 1'b0;
    wait_done();
    check(16'(host.rx_n), 16'(n));
    check(16'(host.last_n), 16'(n));
    for (int j = 0; j < n; j++) begin
      check(16'(host.rx[j]), 16'(exp_byte(j, r[9:8])));
    end
  endtask : sense
  task automatic bad_cmd(input ext_data_pkg::sense_cmd_type c,
      input logic [15:0] fp);
    @(posedge clk);
    sense_cmd <= c;
    sense_req <= 1'b1;
    @(posedge clk);
    sense_req <= 1'b0;
    wait_done();
    check(16'({status.key, status.asc}), 16'h0524);
    check(status.field_ptr, fp);
  endtask : bad_cmd
  task automatic select(input logic [7:0] len, input logic [7:0] b4,
      input logic [7:0] b5, input logic [7:0] pat);
    @(posedge clk);
    sel_len <= len;
    sel_req <= 1'b1;
    @(posedge clk);
    sel_req <= 1'b0;
    for (int i = 0; i < 38 && len == 8'h26; i++) begin
      in_valid <= 1'b1;
      in_data <= i == 4 ? b4 : i == 5 ? b5 : i < 4 ? 8'h00 : 8'(i) ^ pat;
      do @(posedge clk); while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    wait_done();
  endtask : select
  task automatic bad_sel(input logic [7:0] b4, input logic [7:0] b5,
      input logic [15:0] fp, input logic [15:0] bits);
    select(8'h26, b4, b5, 8'h5a);
    check(16'({status.key, status.asc}), 16'h0526);
    check(status.field_ptr, fp);
    check(16'(status.in_command), 16'h0000);
    check(16'({status.bit_valid, status.bit_ptr}), bits);
  endtask : bad_sel
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    check(16'({done, in_ready, out_valid, status.check}), 16'h0000);
    resetn <= 1'b1;
    select(8'h26, 8'h3e, 8'h20, 8'ha5);
    check(16'(status.check), 16'h0000);
    foreach (rows[k]) sense(rows[k], 8'h1a);
    select(8'h25, 8'h3e, 8'h20, 8'h5a);
    check(16'({status.key, status.asc}), 16'h051a);
    check(status.field_ptr, 16'h0004);
    check(16'({status.in_command, status.ascq}), 16'h0100);
    bad_sel(8'hbe, 8'h20, 16'h0004, 16'h000f);
    bad_sel(8'h3d, 8'h20, 16'h0004, 16'h0000);
    bad_sel(8'h3e, 8'h21, 16'h0005, 16'h0000);
    sense(13'h0026, 8'h1a);
    // nothing saved: saved view falls back to defaults
    nv <= 1'b0;
    sense(13'h0307, 8'h1a);
    nv <= 1'b1;
    // mid-run reset must leave the retained bytes alone
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check(16'({done, in_ready, out_valid, status.check}), 16'h0000);
    resetn <= 1'b1;
    sense(13'h0026, 8'h1a);
    bad_cmd('{8'h1a, 1'b0, 2'h0, 6'h3e, 8'h26, 1'b0, 1'b1}, 16'h0005);
    bad_cmd('{8'h1a, 1'b0, 2'h0, 6'h3d, 8'h26, 1'b0, 1'b0}, 16'h0002);
    sense(13'h0026, 8'h12);
    check(16'({status.key, status.asc}), 16'h0524);
    end_of_test();
  end
endmodule : testbench
